// File: shared/itmr_pkg.sv
// Package: constants and carrier types of the interval timer block
package itmr_pkg;
    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 100000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [15:0] CONST_INTERVAL = 16'h0010;

    // ********************************************************************
    // Command codes
    // ********************************************************************
    localparam logic [11:0] CMD_ONESHOT = 12'h000;
    localparam logic [11:0] CMD_SCHED = 12'h003;
    localparam logic [11:0] CMD_READ = 12'h006;
    localparam logic [11:0] CMD_STOP = 12'h010;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [3:0] REG_COMMAND = 4'h0;
    localparam logic [3:0] REG_PRESET = 4'h1;
    localparam logic [3:0] REG_INTERVAL = 4'h2;
    localparam logic [3:0] REG_SUBR = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h5;
    localparam logic [3:0] REG_RD_COUNT = 4'h6;
    localparam logic [3:0] REG_RD_INTERVAL = 4'h7;
    localparam logic [3:0] REG_RD_ELAPSED = 4'h8;
    localparam logic [3:0] REG_STATE = 4'h9;
    localparam logic [15:0] CMD_CONST_BIT = 16'h1000;
    localparam int STS_TIMEOUT = 0;
    localparam int STS_BADCMD = 1;
    localparam logic [1:0] STS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    typedef enum logic [1:0] {
        ITMR_IDLE = 2'b00,
        ITMR_ONESHOT = 2'b01,
        ITMR_SCHED = 2'b10
    } itmr_mode_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] interval;
        logic [15:0] elapsed;
    } itmr_snap_t;
endpackage

// File: hw/itmr_top.sv
// Interval timer with one-shot and scheduled interrupt modes
module itmr_top
#(
    parameter int TICK_DIV = itmr_pkg::TICK_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [15:0] RDATA,
    output logic IRQ,
    output logic SUB_REQ,
    output logic [15:0] SUB_NUM
);
    import itmr_pkg::*;

    // ********************************************************************
    // BCD helpers
    // ********************************************************************
    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (carry) begin
                if (r[i*4 +: 4] == 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (borrow) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    function automatic logic is_cmd(input logic [15:0] w, input logic [11:0] code);
        return w[11:0] == code;
    endfunction

    function automatic itmr_mode_t start_mode(input logic [15:0] w);
        return is_cmd(w, CMD_SCHED) ? ITMR_SCHED : ITMR_ONESHOT;
    endfunction

    // ********************************************************************
    // State
    // ********************************************************************
    itmr_mode_t mode, next_mode;
    logic [15:0] tick_cnt, next_tick_cnt;
    logic tick;
    logic [15:0] preset, next_preset;
    logic [15:0] interval, next_interval;
    logic [15:0] subr, next_subr;
    logic [15:0] load_preset, next_load_preset;
    logic [15:0] load_interval, next_load_interval;
    logic [15:0] load_subr, next_load_subr;
    logic [15:0] count, next_count;
    logic [15:0] done, next_done;
    logic [15:0] elapsed, next_elapsed;
    itmr_snap_t snap, next_snap;
    logic [1:0] status, next_status;
    logic [1:0] mask, next_mask;
    logic [15:0] rdata, next_rdata;
    logic sub_req, next_sub_req;
    logic [15:0] sub_num, next_sub_num;
    logic cmd_wr;
    logic start;
    logic read_cmd;
    logic stop_cmd;
    logic bad_cmd;
    logic timeout;
    logic dec_now;

    // ********************************************************************
    // Command decode
    // ********************************************************************
    assign cmd_wr = WR_EN && (ADDR == REG_COMMAND);
    assign start = cmd_wr && (is_cmd(WDATA, CMD_ONESHOT) || is_cmd(WDATA, CMD_SCHED));
    assign read_cmd = cmd_wr && is_cmd(WDATA, CMD_READ);
    assign stop_cmd = cmd_wr && is_cmd(WDATA, CMD_STOP);
    // Unknown codes are flagged rather than dropped silently
    assign bad_cmd = cmd_wr && !start && !read_cmd && !stop_cmd;

    // ********************************************************************
    // Time base
    // ********************************************************************
    // Tick of 0.1 ms from the core clock
    assign tick = (tick_cnt == 16'(TICK_DIV - 1));
    // Interval done when elapsed ticks reach the interval
    assign dec_now = (mode != ITMR_IDLE) && tick && (bcd_inc(elapsed) == interval);
    // A zero preset times out on the first interval
    assign timeout = dec_now && (count == 16'h0001 || count == 16'h0000);

    // ********************************************************************
    // Tick counter
    // ********************************************************************
    always_comb begin
        next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
        // Restart aligns the first tick with the start command
        if (start) begin
            next_tick_cnt = 16'h0000;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ********************************************************************
    // Setup registers
    // ********************************************************************
    // Preset, interval and subroutine take effect only at the next start command; the mask applies at once
    always_comb begin
        next_load_preset = load_preset;
        next_load_interval = load_interval;
        next_load_subr = load_subr;
        next_mask = mask;
        if (WR_EN) begin
            unique case (ADDR)
                REG_PRESET: next_load_preset = WDATA;
                REG_INTERVAL: next_load_interval = WDATA;
                REG_SUBR: next_load_subr = WDATA;
                REG_MASK: next_mask = WDATA[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            load_preset <= 16'h0000;
            load_interval <= CONST_INTERVAL;
            load_subr <= 16'h0000;
            mask <= MASK_RESET;
        end else begin
            load_preset <= next_load_preset;
            load_interval <= next_load_interval;
            load_subr <= next_load_subr;
            mask <= next_mask;
        end
    end

    // ********************************************************************
    // Timer
    // ********************************************************************
    always_comb begin
        next_mode = mode;
        next_preset = preset;
        next_interval = interval;
        next_subr = subr;
        next_count = count;
        next_done = done;
        next_elapsed = elapsed;
        if (mode != ITMR_IDLE && tick) begin
            next_elapsed = bcd_inc(elapsed);
        end
        if (dec_now) begin
            next_elapsed = 16'h0000;
            next_count = bcd_dec(count);
            next_done = bcd_inc(done);
        end
        if (timeout) begin
            if (mode == ITMR_SCHED) begin
                next_count = preset;
                next_done = 16'h0000;
            end else begin
                next_mode = ITMR_IDLE;
            end
        end
        if (start) begin
            // Restart from scratch, even when already running
            next_mode = start_mode(WDATA);
            next_subr = load_subr;
            next_count = load_preset;
            next_preset = load_preset;
            next_interval = (WDATA & CMD_CONST_BIT) != 16'h0000 ?
                CONST_INTERVAL : load_interval;
            next_done = 16'h0000;
            next_elapsed = 16'h0000;
        end else if (stop_cmd) begin
            next_mode = ITMR_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mode <= ITMR_IDLE;
            preset <= 16'h0000;
            interval <= CONST_INTERVAL;
            subr <= 16'h0000;
            count <= 16'h0000;
            done <= 16'h0000;
            elapsed <= 16'h0000;
        end else begin
            mode <= next_mode;
            preset <= next_preset;
            interval <= next_interval;
            subr <= next_subr;
            count <= next_count;
            done <= next_done;
            elapsed <= next_elapsed;
        end
    end

    // ********************************************************************
    // Status
    // ********************************************************************
    // Set wins over clear for the sticky bits
    always_comb begin
        next_status = status;
        if (WR_EN && ADDR == REG_STATUS) begin
            next_status = status & ~WDATA[1:0];
        end
        if (bad_cmd) begin
            next_status[STS_BADCMD] = 1'b1;
        end
        if (timeout) begin
            next_status[STS_TIMEOUT] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            status <= STS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ********************************************************************
    // Subroutine request
    // ********************************************************************
    always_comb begin
        next_sub_req = 1'b0;
        next_sub_num = sub_num;
        if (timeout) begin
            next_sub_req = 1'b1;
            next_sub_num = subr;
        end
        // A stop in the timeout cycle still swallows the request
        if (stop_cmd) begin
            next_sub_req = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sub_req <= 1'b0;
            sub_num <= 16'h0000;
        end else begin
            sub_req <= next_sub_req;
            sub_num <= next_sub_num;
        end
    end

    // ********************************************************************
    // Read back
    // ********************************************************************
    // Snapshot so the three results belong to one instant
    always_comb begin
        next_snap = snap;
        next_rdata = 16'h0000;
        if (read_cmd) begin
            next_snap.count = done;
            next_snap.interval = interval;
            next_snap.elapsed = (mode == ITMR_IDLE) ? 16'h0000 : elapsed;
        end
        if (RD_EN) begin
            unique case (ADDR)
                REG_PRESET: next_rdata = load_preset;
                REG_INTERVAL: next_rdata = load_interval;
                REG_SUBR: next_rdata = load_subr;
                REG_STATUS: next_rdata = {14'h0000, status};
                REG_MASK: next_rdata = {14'h0000, mask};
                REG_RD_COUNT: next_rdata = snap.count;
                REG_RD_INTERVAL: next_rdata = snap.interval;
                REG_RD_ELAPSED: next_rdata = snap.elapsed;
                REG_STATE: next_rdata = {14'h0000, mode};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            snap <= '0;
            rdata <= 16'h0000;
        end else begin
            snap <= next_snap;
            rdata <= next_rdata;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign RDATA = rdata;
    assign IRQ = |(status & mask);
    assign SUB_REQ = sub_req;
    assign SUB_NUM = sub_num;
endmodule

// File: bench/itmr_chk.sv
// Checker: concurrent properties on the interval timer ports
module itmr_chk
    import itmr_pkg::*;
#(
    parameter int TICK_DIV = 4
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] RDATA,
    input wire logic IRQ,
    input wire logic SUB_REQ,
    input wire logic [15:0] SUB_NUM
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cmd_wr;
    logic mask0;
    logic next_mask0;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    assign cmd_wr = WR_EN && ADDR == REG_COMMAND;
    always_comb begin
        next_mask0 = (WR_EN && ADDR == REG_MASK) ? WDATA[0] : mask0;
    end
    always_ff @(posedge CORE_CLK) begin
        mask0 <= SYS_RST ? 1'b0 : next_mask0;
    end
    // ********
    // Properties
    // ********
    chk_sub_pulse: assert property (SUB_REQ |=> !SUB_REQ)
        else $error("sub request longer than a cycle");
    chk_start_quiet: assert property (cmd_wr && (WDATA[11:0] == CMD_ONESHOT
        || WDATA[11:0] == CMD_SCHED) |=> ##1 !SUB_REQ [*8])
        else $error("timeout too soon after start");
    chk_stop_quiet: assert property (cmd_wr && WDATA[11:0] == CMD_STOP
        |=> ##1 !SUB_REQ [*8])
        else $error("timeout after stop");
    chk_num_with_req: assert property ($changed(SUB_NUM) |-> SUB_REQ)
        else $error("subroutine number moved without request");
    chk_rdata_idle: assert property (!RD_EN |=> RDATA == 16'h0000)
        else $error("read data outside read slot");
    chk_rd_unmapped: assert property (RD_EN && ADDR > REG_STATE |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    chk_mask_off: assert property (WR_EN && ADDR == REG_MASK && WDATA[1:0] == 2'h0
        |=> !IRQ)
        else $error("interrupt while masked");
    chk_irq_follow: assert property (SUB_REQ && mask0 |-> ##[0:1] IRQ)
        else $error("interrupt late after timeout");
    cover property (SUB_REQ && mask0);
    cover property (cmd_wr && WDATA[11:0] == CMD_STOP);
    cover property (RD_EN && ADDR == REG_RD_ELAPSED);
endmodule

bind itmr_top itmr_chk #(.TICK_DIV(TICK_DIV)) u_chk (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .IRQ(IRQ),
    .SUB_REQ(SUB_REQ), .SUB_NUM(SUB_NUM)
);

// File: bench/itmr_host.sv
// Controller model: register writes and reads on the timer bus
module itmr_host (
    input wire logic CORE_CLK,
    output logic [3:0] ADDR,
    output logic [15:0] WDATA,
    output logic WR_EN,
    output logic RD_EN,
    input wire logic [15:0] RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ADDR = 4'h0;
        WDATA = 16'h0000;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
    end
    // Idle bus lines flip so a stale value never passes for a fresh one
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge CORE_CLK);
        WR_EN <= 1'b0;
        ADDR <= ~a;
        WDATA <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CORE_CLK);
        RD_EN <= 1'b0;
        ADDR <= ~a;
        @(negedge CORE_CLK);
        d = RDATA;
    endtask
endmodule

// File: bench/tb.sv
// Testbench: random and corner scenarios for the interval timer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import itmr_pkg::*;
    localparam int TDIV = 4;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [3:0] ADDR;
    logic [15:0] WDATA, RDATA, SUB_NUM, rv;
    logic WR_EN, RD_EN, IRQ, SUB_REQ;
    int err_total = 0;
    int n_tests = 0;
    int n, p, iv, s;
    itmr_top #(.TICK_DIV(TDIV)) i_dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
        .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
        .IRQ(IRQ), .SUB_REQ(SUB_REQ), .SUB_NUM(SUB_NUM));
    itmr_host i_host (.CORE_CLK(CORE_CLK), .ADDR(ADDR), .WDATA(WDATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA));
    initial begin
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    // ********
    // Helpers
    // ********
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [15:0] bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    // Preset zero still waits one interval
    function automatic int span(input int pv, input int ivl);
        return (pv == 0 ? 1 : pv) * ivl * TDIV;
    endfunction
    task automatic start(input logic [15:0] c);
        i_host.wr(REG_PRESET, bcd(p));
        i_host.wr(REG_INTERVAL, bcd(iv));
        i_host.wr(REG_SUBR, bcd(s));
        i_host.wr(REG_COMMAND, c);
    endtask
    task automatic wait_sub(input int lim);
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (SUB_REQ !== 1'b1 && n < lim);
    endtask
    task automatic delay_ok(input int e);
        check("delay", 16'(n >= e && n <= e + 3), 16'h0001);
        check("subroutine", SUB_NUM, bcd(s));
    endtask
    initial begin
        #3000000;
        err_total++;
        finish_test();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        void'($urandom(32'h7D25));
        repeat (4) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        i_host.rd(REG_STATUS, rv);
        check("status reset", rv, 16'h0000);
        i_host.rd(4'hF, rv);
        check("unmapped", rv, 16'h0000);
        i_host.wr(REG_MASK, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 0 : $urandom_range(9, 1);
            iv = (k == 1) ? 5 : $urandom_range(12, 5);
            s = (k == 2) ? 49 : $urandom_range(48, 0);
            start({4'h0, CMD_ONESHOT});
            wait_sub(4000);
            delay_ok(span(p, iv));
            repeat (2) @(posedge CORE_CLK);
            check("irq", {15'h0, IRQ}, 16'h0001);
            wait_sub(span(p, iv) + 8);
            check("one shot", {15'h0, SUB_REQ}, 16'h0000);
            i_host.wr(REG_COMMAND, {4'h0, CMD_READ});
            i_host.rd(REG_RD_ELAPSED, rv);
            check("halted elapsed", rv, 16'h0000);
            i_host.wr(REG_STATUS, 16'h0001);
            i_host.rd(REG_STATUS, rv);
            check("status clear", rv, 16'h0000);
        end
        p = $urandom_range(5, 3);
        iv = $urandom_range(9, 5);
        s = $urandom_range(49, 0);
        start({4'h0, CMD_SCHED});
        wait_sub(4000);
        wait_sub(4000);
        check("period", 16'(n), 16'(span(p, iv)));
        repeat (iv * TDIV * 2 + 1) @(posedge CORE_CLK);
        i_host.wr(REG_COMMAND, {4'h0, CMD_READ});
        i_host.rd(REG_RD_COUNT, rv);
        check("decrements", rv, 16'h0002);
        i_host.rd(REG_RD_INTERVAL, rv);
        check("interval", rv, bcd(iv));
        i_host.wr(REG_COMMAND, {4'h0, CMD_STOP});
        wait_sub(span(p, iv) * 2);
        check("after stop", {15'h0, SUB_REQ}, 16'h0000);
        i_host.rd(REG_STATE, rv);
        check("mode", rv, 16'h0000);
        p = 3;
        iv = 6;
        start({4'h0, CMD_ONESHOT});
        repeat (30) @(posedge CORE_CLK);
        p = 2;
        iv = 5;
        s = $urandom_range(49, 0);
        start(CMD_CONST_BIT | {4'h0, CMD_ONESHOT});
        wait_sub(4000);
        delay_ok(span(2, 10));
        i_host.wr(REG_COMMAND, 16'h0001);
        i_host.rd(REG_STATUS, rv);
        check("bad command", rv, 16'h0003);
        i_host.wr(REG_MASK, 16'h0000);
        @(negedge CORE_CLK);
        check("masked", {15'h0, IRQ}, 16'h0000);
        i_host.wr(REG_STATUS, 16'h0003);
        i_host.wr(REG_MASK, 16'h0003);
        @(negedge CORE_CLK);
        check("cleared", {15'h0, IRQ}, 16'h0000);
        finish_test();
    end
endmodule
